// ---- src/ecp_consts.vh ----
// Constants for the extended-capabilities parallel port controller
`ifndef ECP_CONSTS_VH
`define ECP_CONSTS_VH
// Register offsets (base relative)
`define OFF_DATA 11'h000
`define OFF_STATUS 11'h001
`define OFF_CONTROL 11'h002
`define OFF_FIFO 11'h400
`define OFF_CFGB 11'h401
`define OFF_ECR 11'h402
// Mode field encodings
`define MODE_STD 3'h0
`define MODE_PS2 3'h1
`define MODE_PFIFO 3'h2
`define MODE_ECP 3'h3
`define MODE_EPP 3'h4
`define MODE_TEST 3'h6
`define MODE_CFG 3'h7
// Fixed values
`define CFGA_VALUE 8'h10
`define CFGB_IRQ_RESET 3'h0
`define FIFO_DEPTH 16
`define FIFO_AW 4
// Strobe pulse width: 500 ns at 20 ns period
`define STB_TIME_NS 500
`define CLK_PERIOD_NS 20
`define STB_CYCLES ((`STB_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ---- src/byte_fifo.v ----
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module byte_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  input wire clr,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  // Fill level
  output wire [AW:0] level
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;

  // Handshakes
  assign in_ready = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_r];
  assign level = count_r;

  // Pointer and count
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end
    else if (clr)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      if (push && !pop)
        count_r <= count_r + 1'b1;
      else if (pop && !push)
        count_r <= count_r - 1'b1;
    end
  end

  // Storage
  always @(posedge core_clk)
  begin
    if (push)
      mem[wr_ptr_r] <= in_data;
  end

endmodule

// ---- src/ecp_parallel_port_controller.v ----
// Extended-capabilities parallel port controller, host I/O side and line side
`timescale 1ns/10ps
`include "ecp_consts.vh"
module ecp_parallel_port_controller #(
  parameter FREE_SPACE_THRESHOLD = 8,
  parameter VALID_BYTES_THRESHOLD = 8,
  parameter STB_WIDTH = `STB_CYCLES
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Host I/O port
  input wire [10:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata,
  // DMA and interrupt
  output wire dma_request_pin,
  input wire dma_ack,
  input wire dma_tc,
  output wire irq_out,
  output wire fault_irq_pulse,
  input wire irq_line_level,
  // Parallel data lines
  input wire [7:0] pd_in,
  output wire [7:0] pd_out,
  output wire pd_oe_n,
  // Peripheral inputs
  input wire busy_input,
  input wire peripheral_acknowledge_input,
  input wire paper_out_input,
  input wire select_input,
  input wire peripheral_error_input,
  // Peripheral outputs
  output wire strobe_output,
  output wire auto_feed_output,
  output wire init_output,
  output wire select_in_output
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  reg [12:0] sync1_r;
  reg [12:0] sync2_r;
  reg ack_d_r;
  reg err_d_r;
  wire [7:0] pd_s;
  wire busy_s, ack_s, pe_s, sel_s, err_s;

  // Two-flop sync of all pin inputs
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Active-low acknowledge and error start at their idle high level: no false edge
      sync1_r <= 13'h0009;
      sync2_r <= 13'h0009;
      ack_d_r <= 1'b1;
      err_d_r <= 1'b1;
    end
    else
    begin
      sync1_r <= {pd_in, busy_input, peripheral_acknowledge_input, paper_out_input, select_input,
                  peripheral_error_input};
      sync2_r <= sync1_r;
      ack_d_r <= sync2_r[3];
      err_d_r <= sync2_r[0];
    end
  end
  assign pd_s = sync2_r[12:5];
  assign busy_s = sync2_r[4];
  assign ack_s = sync2_r[3];
  assign pe_s = sync2_r[2];
  assign sel_s = sync2_r[1];
  assign err_s = sync2_r[0];

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg [7:0] port_data_latch_r;
  reg [5:0] line_control_r;
  reg [2:0] mode_r;
  reg fault_interrupt_enable_r;
  reg dma_enable_bit_r;
  reg service_interrupt_flag_r;
  reg [2:0] cfgb_low_r;
  reg [2:0] irq_select_r;
  reg [7:0] last_rd_r;
  reg ack_irq_r;
  reg [7:0] stb_cnt_r;
  reg [1:0] tx_state_r;
  reg [7:0] tx_byte_r;
  reg tx_tag_r;

  wire [8:0] fifo_in_data;
  wire [8:0] fifo_out_data;
  wire [4:0] fifo_level;
  wire dir_eff, fifo_clr, fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  wire fifo_full, fifo_empty, wr_fifo_port, rd_fifo_port, wr_afifo, host_push, host_pop;
  wire rx_push, tx_pop, dma_push, dma_pop, svc_event, fault_edge, ack_rise;

  // Direction in effect: ignored in modes 000 and 010
  assign dir_eff = (mode_r == `MODE_STD || mode_r == `MODE_PFIFO) ? 1'b0 : line_control_r[5];
  assign fifo_clr = (mode_r == `MODE_STD);

  // FIFO port decode per mode
  assign wr_fifo_port = io_wr && io_addr == `OFF_FIFO &&
    (mode_r == `MODE_PFIFO || mode_r == `MODE_ECP || mode_r == `MODE_TEST);
  assign rd_fifo_port = io_rd && io_addr == `OFF_FIFO &&
    ((mode_r == `MODE_ECP && dir_eff) || mode_r == `MODE_TEST);
  assign wr_afifo = io_wr && io_addr == `OFF_DATA && mode_r == `MODE_ECP && !dir_eff;

  // DMA moves bytes in the direction in effect
  assign dma_push = dma_ack && !dir_eff && mode_r != `MODE_STD;
  assign dma_pop = dma_ack && dir_eff && mode_r != `MODE_STD;

  // Fill side: host, DMA or reverse ECP receive; full drops the write
  assign host_push = wr_fifo_port || wr_afifo || dma_push;
  assign rx_push = (mode_r == `MODE_ECP) && dir_eff && (ack_d_r && !ack_s);
  assign fifo_in_valid = host_push || rx_push;
  assign fifo_in_data = wr_afifo ? {1'b1, io_wdata} : (rx_push ? {1'b0, pd_s} : {1'b0, io_wdata});
  assign host_pop = (rd_fifo_port || dma_pop) && fifo_out_valid;
  assign fifo_out_ready = host_pop || tx_pop;
  assign fifo_full = !fifo_in_ready;
  assign fifo_empty = !fifo_out_valid;

  byte_fifo #(
    .WIDTH(9),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clr(fifo_clr),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // ------------------------------------------------------------
  // Forward transmitter: standard and ECP handshake
  // ------------------------------------------------------------
  localparam TX_IDLE = 2'h0;
  localparam TX_WAIT = 2'h1;
  localparam TX_STB = 2'h2;
  localparam TX_DONE = 2'h3;

  // Transmit only in 010 or forward ECP, never in test mode
  assign tx_pop = (tx_state_r == TX_IDLE) && fifo_out_valid && !dir_eff &&
    (mode_r == `MODE_PFIFO || mode_r == `MODE_ECP);

  // Handshake: wait not busy, pulse strobe, then in ECP mode wait for busy high
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_state_r <= TX_IDLE;
      tx_byte_r <= 8'h00;
      tx_tag_r <= 1'b0;
      stb_cnt_r <= 8'h00;
    end
    else if (fifo_clr)
      tx_state_r <= TX_IDLE;
    else
    begin
      case (tx_state_r)
        TX_IDLE:
        begin
          if (tx_pop)
          begin
            tx_byte_r <= fifo_out_data[7:0];
            tx_tag_r <= fifo_out_data[8];
            tx_state_r <= TX_WAIT;
          end
        end
        TX_WAIT:
        begin
          if (!busy_s)
          begin
            stb_cnt_r <= STB_WIDTH[7:0];
            tx_state_r <= TX_STB;
          end
        end
        TX_STB:
        begin
          if (stb_cnt_r <= 8'h01)
            tx_state_r <= TX_DONE;
          else
            stb_cnt_r <= stb_cnt_r - 8'h01;
        end
        TX_DONE:
        begin
          if (mode_r == `MODE_PFIFO || busy_s)
            tx_state_r <= TX_IDLE;
        end
        default:
          tx_state_r <= TX_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Register writes, service flag and interrupts
  // ------------------------------------------------------------
  assign svc_event = dma_enable_bit_r ? (dma_tc && dma_ack) :
    (!dir_eff ? ((`FIFO_DEPTH - fifo_level) >= FREE_SPACE_THRESHOLD) :
     (fifo_level >= VALID_BYTES_THRESHOLD));
  assign fault_edge = err_d_r && !err_s;
  assign ack_rise = !ack_d_r && ack_s;

  // Control, extended control, config B
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_data_latch_r <= 8'h00;
      line_control_r <= 6'h00;
      mode_r <= `MODE_STD;
      fault_interrupt_enable_r <= 1'b0;
      dma_enable_bit_r <= 1'b0;
      service_interrupt_flag_r <= 1'b1;
      cfgb_low_r <= 3'h7;
      irq_select_r <= `CFGB_IRQ_RESET;
      ack_irq_r <= 1'b0;
    end
    else
    begin
      if (io_wr && io_addr == `OFF_DATA && (mode_r == `MODE_STD || mode_r == `MODE_PS2))
        port_data_latch_r <= io_wdata;
      if (io_wr && io_addr == `OFF_CONTROL)
        line_control_r <= io_wdata[5:0];
      if (io_wr && io_addr == `OFF_CFGB && mode_r == `MODE_CFG)
        cfgb_low_r <= io_wdata[2:0];
      if (io_wr && io_addr == `OFF_ECR)
      begin
        mode_r <= io_wdata[7:5];
        fault_interrupt_enable_r <= io_wdata[4];
        dma_enable_bit_r <= io_wdata[3];
      end
      // Hardware set wins over a software clear
      if (!service_interrupt_flag_r && svc_event && mode_r != `MODE_STD)
        service_interrupt_flag_r <= 1'b1;
      else if (io_wr && io_addr == `OFF_ECR)
        service_interrupt_flag_r <= io_wdata[2];
      // Acknowledge interrupt held until status read
      if (line_control_r[4] && ack_rise)
        ack_irq_r <= 1'b1;
      else if (io_rd && io_addr == `OFF_STATUS)
        ack_irq_r <= 1'b0;
    end
  end

  assign dma_request_pin = dma_enable_bit_r && !service_interrupt_flag_r &&
    (mode_r != `MODE_STD) && (dir_eff ? fifo_out_valid : fifo_in_ready);
  assign fault_irq_pulse = (mode_r == `MODE_ECP) && fault_interrupt_enable_r && fault_edge;
  // Service interrupt fires only in the cycle in which hardware sets the flag
  assign irq_out = ack_irq_r || fault_irq_pulse ||
    (!service_interrupt_flag_r && svc_event && mode_r != `MODE_STD);

  // ------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      last_rd_r <= 8'h00;
    else if (host_pop)
      last_rd_r <= fifo_out_data[7:0];
  end

  // Read data mux
  always @*
  begin
    io_rdata = 8'h00;
    case (io_addr)
      `OFF_DATA:
        io_rdata = (mode_r == `MODE_PS2) ? pd_s :
                   (mode_r == `MODE_STD ? pd_s : port_data_latch_r);
      `OFF_STATUS:
        io_rdata = {~busy_s, ack_s, pe_s, sel_s, err_s, 3'h7};
      `OFF_CONTROL:
        io_rdata = {2'h3, line_control_r};
      `OFF_FIFO:
        io_rdata = (mode_r == `MODE_CFG) ? `CFGA_VALUE :
                   (host_pop ? fifo_out_data[7:0] : last_rd_r);
      `OFF_CFGB:
        io_rdata = (mode_r == `MODE_CFG) ? {1'b0, irq_line_level, irq_select_r, cfgb_low_r} : 8'h00;
      `OFF_ECR:
        io_rdata = {mode_r, fault_interrupt_enable_r, dma_enable_bit_r, service_interrupt_flag_r,
                    fifo_full, fifo_empty};
      default:
        io_rdata = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // Line drivers
  // ------------------------------------------------------------
  // Data lines: latch in SPP/PS2, FIFO byte while transmitting
  assign pd_out = (tx_state_r != TX_IDLE) ? tx_byte_r : port_data_latch_r;
  assign pd_oe_n = dir_eff;
  // Strobe and auto-feed inverted; handshake strobe and address tag override
  assign strobe_output = (tx_state_r == TX_STB) ? 1'b0 : ~line_control_r[0];
  assign auto_feed_output = (mode_r == `MODE_ECP && tx_state_r != TX_IDLE) ? ~tx_tag_r :
    ~line_control_r[1];
  assign init_output = line_control_r[2];
  assign select_in_output = ~line_control_r[3];

endmodule

// ---- tb/ecp_port_checker.sv ----
// Assertion checker bound to the parallel port controller
`timescale 1ns/10ps
module ecp_port_checker (
  // Clock, reset and host port
  input wire core_clk,
  input wire rst_n,
  input wire [10:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  input wire [7:0] io_rdata,
  // DMA, interrupts and line signals
  input wire dma_request_pin,
  input wire dma_ack,
  input wire dma_tc,
  input wire irq_out,
  input wire fault_irq_pulse,
  input wire pd_oe_n,
  input wire peripheral_acknowledge_input,
  input wire strobe_output,
  input wire auto_feed_output,
  input wire init_output,
  input wire select_in_output
);
  reg [2:0] mode_r;
  reg [4:0] ctl_r;
  reg dma_en_r;
  // Shadow of mode, DMA enable and control bits taken from host writes
  always @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      mode_r <= 3'h0;
      ctl_r <= 5'h00;
      dma_en_r <= 1'b0;
    end
    else
    begin
      if (io_wr && io_addr == 11'h402)
        {mode_r, dma_en_r} <= {io_wdata[7:5], io_wdata[3]};
      if (io_wr && io_addr == 11'h002)
        ctl_r <= io_wdata[4:0];
    end
  // ------
  // Properties
  // ------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_pins; {init_output, select_in_output} == {ctl_r[2], !ctl_r[3]} &&
    (mode_r == 3'h3 || auto_feed_output == !ctl_r[1]); endproperty
  a_pins: assert property (p_pins) else $error("control pins wrong");
  property p_stat; io_rd && io_addr == 11'h001 |-> io_rdata[2:0] == 3'h7; endproperty
  a_stat: assert property (p_stat) else $error("status low bits wrong");
  property p_ctl; io_rd && io_addr == 11'h002 |-> io_rdata[7:6] == 2'h3; endproperty
  a_ctl: assert property (p_ctl) else $error("control high bits wrong");
  property p_cfga; io_rd && io_addr == 11'h400 && mode_r == 3'h7 |-> io_rdata == 8'h10; endproperty
  a_cfga: assert property (p_cfga) else $error("config A wrong");
  property p_oe; (mode_r == 3'h0 || mode_r == 3'h2) && $stable(mode_r) |-> !pd_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("data lines not driven");
  property p_dma; !dma_en_r || mode_r == 3'h0 |-> !dma_request_pin; endproperty
  a_dma: assert property (p_dma) else $error("DMA request while disabled");
  property p_tc; dma_ack && dma_tc |=> (!dma_request_pin) [*2]; endproperty
  a_tc: assert property (p_tc) else $error("DMA request after terminal count");
  property p_quiet; mode_r == 3'h6 && $past(mode_r) == 3'h6 |-> strobe_output == !ctl_r[0]; endproperty
  a_quiet: assert property (p_quiet) else $error("strobe moved in test mode");
  property p_fault; fault_irq_pulse |-> mode_r == 3'h3 ##1 !fault_irq_pulse; endproperty
  a_fault: assert property (p_fault) else $error("fault pulse wrong");
  property p_ack; ctl_r[4] && $rose(peripheral_acknowledge_input) |-> ##[1:5] irq_out; endproperty
  a_ack: assert property (p_ack) else $error("no acknowledge interrupt");
  c_tc: cover property (dma_ack && dma_tc);
  c_fault: cover property (fault_irq_pulse);
  c_addr: cover property (io_wr && io_addr == 11'h000 && mode_r == 3'h3);
endmodule
bind ecp_parallel_port_controller ecp_port_checker u_chk (.core_clk(core_clk), .rst_n(rst_n),
  .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .dma_request_pin(dma_request_pin), .dma_ack(dma_ack), .dma_tc(dma_tc), .irq_out(irq_out),
  .fault_irq_pulse(fault_irq_pulse), .pd_oe_n(pd_oe_n),
  .peripheral_acknowledge_input(peripheral_acknowledge_input), .strobe_output(strobe_output),
  .auto_feed_output(auto_feed_output), .init_output(init_output), .select_in_output(select_in_output));

// ---- tb/printer_model.sv ----
// Peripheral model on the parallel lines
`timescale 1ns/10ps
module printer_model (
  // Clock and lines from the host
  input wire core_clk,
  input wire strobe_n,
  input wire [7:0] pd_out,
  input wire [7:0] dly,
  // Lines to the host
  output logic busy,
  output logic ack_n,
  output logic [7:0] pd_rev
);
  logic [7:0] got[$];
  initial
  begin
    busy = 1'b0;
    ack_n = 1'b1;
    pd_rev = 8'hA5;
  end
  // Forward: take the byte, hold busy, acknowledge after a delay
  always @(negedge strobe_n)
  begin
    @(posedge core_clk);
    got.push_back(pd_out);
    busy <= 1'b1;
    wait (strobe_n);
    repeat (dly) @(posedge core_clk);
    ack_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    ack_n <= 1'b1;
    busy <= 1'b0;
  end
  // Reverse: set up a byte, clock it with a falling ack, then let it go
  task send(input [7:0] b);
    @(posedge core_clk);
    pd_rev <= b;
    repeat (3) @(posedge core_clk);
    ack_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    ack_n <= 1'b1;
    pd_rev <= ~b;
    repeat (4) @(posedge core_clk);
  endtask
endmodule

// ---- tb/ecp_parallel_port_controller_tb.sv ----
// Self-checking bench for the parallel port controller
`timescale 1ns/10ps
module ecp_parallel_port_controller_tb;
  logic core_clk, rst_n, io_wr, io_rd, dma_ack, dma_tc, irq_lvl, pe, sel, err, hit;
  logic [10:0] io_addr;
  logic [7:0] io_wdata, rv, q, dly;
  logic [7:0] fq[$];
  wire [7:0] io_rdata, pd_out, pd_rev;
  wire dreq, irq, fpul, oe_n, busy, ack_n, stb_n, afd_n, init, select_in_output_n;
  wire [7:0] pd_in = oe_n ? pd_rev : pd_out;
  int errors, check_count, i;
  ecp_parallel_port_controller u_dut (.core_clk(core_clk), .rst_n(rst_n), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .dma_request_pin(dreq),
    .dma_ack(dma_ack), .dma_tc(dma_tc), .irq_out(irq), .fault_irq_pulse(fpul), .irq_line_level(irq_lvl),
    .pd_in(pd_in), .pd_out(pd_out), .pd_oe_n(oe_n), .busy_input(busy), .peripheral_acknowledge_input(ack_n),
    .paper_out_input(pe), .select_input(sel), .peripheral_error_input(err), .strobe_output(stb_n),
    .auto_feed_output(afd_n), .init_output(init), .select_in_output(select_in_output_n));
  printer_model u_prt (.core_clk(core_clk), .strobe_n(stb_n), .pd_out(pd_out), .dly(dly), .busy(busy),
    .ack_n(ack_n), .pd_rev(pd_rev));
  // Clock
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // ------
  // Tasks
  // ------
  task chk(input [7:0] seen, input [7:0] exp, input string nm);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Register access held from a falling edge through the next rising edge
  task bus(input w, input [10:0] a, input [7:0] d);
    @(negedge core_clk);
    io_addr = a;
    io_wr = w;
    io_rd = !w;
    io_wdata = d;
    @(posedge core_clk);
    rv = io_rdata;
    @(negedge core_clk);
    io_wr = 1'b0;
    io_rd = 1'b0;
  endtask
  task rd(input [10:0] a, input [7:0] e, input string nm);
    bus(0, a, 8'h00);
    chk(rv, e, nm);
  endtask
  task ecr(input [7:0] v);
    bus(1, 11'h402, v);
  endtask
  // Wait for n bytes at the peripheral, compare with the model queue
  task drain(input int n);
    int k;
    for (k = 0; k < 9000 && u_prt.got.size() < n; k++)
      @(negedge core_clk);
    for (k = 0; k < n; k++)
      chk(u_prt.got.size() > 0 ? u_prt.got.pop_front() : 8'hXX, fq.pop_front(), "line byte");
  endtask
  task stop_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    {io_wr, io_rd, dma_ack, dma_tc, irq_lvl, pe, sel, err, rst_n} = 9'h002;
    io_addr = 11'h000;
    io_wdata = 8'h00;
    dly = 8'h02;
    errors = 0;
    check_count = 0;
    i = $urandom(32'h1122);
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    rd(11'h402, 8'h05, "ecr");
    rd(11'h002, 8'hC0, "control");
    for (i = 0; i < 4; i++)
    begin
      q = $urandom;
      {pe, sel, err} = q[2:0];
      // Strobe stays idle here; direction may only change outside modes 000 and 010
      bus(1, 11'h002, q & 8'hCE);
      bus(1, 11'h000, ~q);
      chk({oe_n, pd_out[7:1]}, {1'b0, ~q[7:1]}, "lines");
      repeat (2) @(negedge core_clk);
      rd(11'h000, ~q, "data");
      rd(11'h001, {~busy, ack_n, pe, sel, err, 3'h7}, "status");
      chk({stb_n, afd_n, select_in_output_n, init}, {1'b1, ~q[1], ~q[3], q[2]}, "pins");
      rd(11'h002, {2'h3, 2'h0, q[3:1], 1'b0}, "control");
    end
    // Strobe bit alone, then let the peripheral finish and forget the byte
    bus(1, 11'h002, 8'h01);
    chk({7'h00, stb_n}, 8'h00, "strobe");
    bus(1, 11'h002, 8'h00);
    repeat (12) @(negedge core_clk);
    u_prt.got.delete();
    err = 1'b1;
    ecr(8'h24);
    bus(1, 11'h002, 8'h20);
    chk({7'h00, oe_n}, 8'h01, "released");
    q = $urandom;
    u_prt.send(q);
    rd(11'h000, ~q, "line read");
    ecr(8'h64);
    repeat (3)
    begin
      q = $urandom;
      fq.push_back(q);
      u_prt.send(q);
    end
    for (i = 0; i < 3; i++)
      rd(11'h400, fq.pop_front(), "reverse");
    rd(11'h402, 8'h65, "ecr");
    ecr(8'h24);
    bus(1, 11'h002, 8'h00);
    ecr(8'h04);
    $display("test legacy and reverse done");
    ecr(8'hC4);
    for (i = 0; i < 17; i++)
    begin
      q = $urandom;
      bus(1, 11'h400, q);
      if (fq.size() < 16)
        fq.push_back(q);
    end
    rd(11'h402, 8'hC6, "full");
    for (i = 0; i < 16; i++)
    begin
      q = fq.pop_front();
      rd(11'h400, q, "fifo");
    end
    rd(11'h400, q, "empty read");
    bus(1, 11'h400, q);
    ecr(8'h04);
    ecr(8'hC4);
    rd(11'h402, 8'hC5, "cleared");
    ecr(8'hC0);
    rd(11'h402, 8'hC5, "service");
    ecr(8'hC8);
    chk({7'h00, dreq}, 8'h01, "dma on");
    for (i = 0; i < 4; i++)
    begin
      @(negedge core_clk);
      q = $urandom;
      fq.push_back(q);
      io_wdata = q;
      dma_ack = 1'b1;
      dma_tc = i == 3;
    end
    @(negedge core_clk);
    {dma_ack, dma_tc} = 2'h0;
    chk({7'h00, dreq}, 8'h00, "dma stop");
    rd(11'h402, 8'hCC, "service");
    ecr(8'hC4);
    for (i = 0; i < 4; i++)
      rd(11'h400, fq.pop_front(), "dma byte");
    $display("test fifo done");
    ecr(8'h04);
    ecr(8'h44);
    for (i = 0; i < 12; i++)
    begin
      if (i == 6)
      begin
        drain(6);
        ecr(8'h04);
        ecr(8'h64);
        dly = 8'h1E;
      end
      q = $urandom;
      fq.push_back(q);
      bus(1, (i < 6 || i[0]) ? 11'h400 : 11'h000, q);
    end
    drain(6);
    repeat (100) @(negedge core_clk);
    ecr(8'h74);
    err = 1'b0;
    hit = 1'b0;
    repeat (20)
      @(negedge core_clk) hit = hit | fpul;
    chk({7'h00, hit}, 8'h01, "fault");
    err = 1'b1;
    ecr(8'h04);
    bus(1, 11'h002, 8'h10);
    u_prt.send(8'h00);
    @(negedge core_clk);
    chk({7'h00, irq}, 8'h01, "ack irq");
    bus(0, 11'h001, 8'h00);
    chk({7'h00, irq}, 8'h00, "irq clear");
    bus(1, 11'h002, 8'h00);
    $display("test transfers done");
    irq_lvl = q[0];
    ecr(8'hE4);
    rd(11'h400, 8'h10, "config a");
    bus(1, 11'h401, 8'h07);
    rd(11'h401, {1'b0, q[0], 6'h07}, "config b");
    ecr(8'h04);
    for (i = 0; i < 8; i++)
    begin
      ecr({i[2:0], 5'h04});
      rd(11'h402, {i[2:0], 5'h05}, "mode");
      ecr(8'h04);
    end
    $display("test config and modes done");
    stop_test;
  end
  // Cut a hung run short
  initial
  begin
    #1000000;
    errors++;
    stop_test;
  end
endmodule
